// ===== hdl/jas_pkg.sv
// Package: constants for the test-access path selector
package jas_pkg;
    // Test-access controller states (IEEE 1149.1 style)
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } jas_tap_state_t;

    // Instruction register width and codes
    localparam int unsigned IR_WIDTH     = 4;
    localparam logic [3:0]  IR_RESET_VAL = 4'h1;
    localparam logic [3:0]  IR_IDCODE    = 4'h1;
    localparam logic [3:0]  IR_BYPASS    = 4'hf;
    localparam logic [1:0]  IR_CAPTURE   = 2'h1;
    // Identification word: value is arbitrary
    localparam logic [31:0] ID_WORD      = 32'h0000_1001;
    localparam int unsigned ID_WIDTH     = 32;
    // Bit positions of the test inputs inside the synchroniser vector
    localparam int unsigned SYNC_PIN_TCK  = 0;
    localparam int unsigned SYNC_PIN_TDI  = 1;
    localparam int unsigned SYNC_PIN_TMS  = 2;
    localparam int unsigned SYNC_CORE_TCK = 3;
    localparam int unsigned SYNC_CORE_TDI = 4;
    localparam int unsigned SYNC_CORE_TMS = 5;
    localparam int unsigned SYNC_SEL      = 6;
    localparam int unsigned SYNC_WIDTH    = 7;
endpackage : jas_pkg

// ===== hdl/jas_access_select.sv
// Module: selects pin-side or core-side path into the test-access controller
`timescale 1ns/100ps
// Operation
// - Pin-side path via dedicated test pins
// - Core-side path driven from fabric logic
// - Only one path drives controller ever
// - Select high: core path, pins disabled
// - Select low: pin path restored
// - Select low on entry to user mode
module jas_access_select (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Pin-side test signals
    input  wire logic pin_tck_i,
    input  wire logic pin_tdi_i,
    input  wire logic pin_tms_i,
    output logic      pin_tdo_o,
    output logic      pin_tdo_oe_n_o,
    // Core-side test signals
    input  wire logic core_sel_i,
    input  wire logic core_tck_i,
    input  wire logic core_tdi_i,
    input  wire logic core_tms_i,
    output logic      core_tdo_o,
    // Status
    output logic      core_active_o
);
    // Two-flop synchronisers for every asynchronous input
    // A metastable level settles in the first stage; only the second stage is read
    logic [jas_pkg::SYNC_WIDTH-1:0] sync1_q;
    logic [jas_pkg::SYNC_WIDTH-1:0] sync2_q;
    logic [jas_pkg::SYNC_WIDTH-1:0] raw_in;
    assign raw_in = {core_sel_i, core_tms_i, core_tdi_i, core_tck_i, pin_tms_i, pin_tdi_i, pin_tck_i};

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    // Selected path; reset holds the pin side in control
    // The select passes one more register so the mux and output gating swap together
    logic sel_q;
    logic sel_d;
    logic tck_prev_q;
    logic tck_prev_d;
    logic mux_tck;
    logic mux_tdi;
    logic mux_tms;
    logic tck_rise;
    logic tck_fall;
    logic sel_change;

    always_comb begin
        sel_d = sync2_q[jas_pkg::SYNC_SEL];
        sel_change = sel_d != sel_q;
        // One path only reaches the controller at any time
        mux_tck = sel_q ? sync2_q[jas_pkg::SYNC_CORE_TCK] : sync2_q[jas_pkg::SYNC_PIN_TCK];
        mux_tdi = sel_q ? sync2_q[jas_pkg::SYNC_CORE_TDI] : sync2_q[jas_pkg::SYNC_PIN_TDI];
        mux_tms = sel_q ? sync2_q[jas_pkg::SYNC_CORE_TMS] : sync2_q[jas_pkg::SYNC_PIN_TMS];
        tck_prev_d = mux_tck;
        // A path switch suppresses edges only in the last cycle on the old path; the first cycle on the new path still compares with the old clock level
        // Limitation: switch paths only while both test clocks are quiet
        tck_rise = mux_tck & ~tck_prev_q & ~sel_change;
        tck_fall = ~mux_tck & tck_prev_q & ~sel_change;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sel_q      <= 1'b0;
            tck_prev_q <= 1'b0;
        end else begin
            sel_q      <= sel_d;
            tck_prev_q <= tck_prev_d;
        end
    end

    // Controller state, instruction and data shift registers
    jas_pkg::jas_tap_state_t state_q;
    jas_pkg::jas_tap_state_t state_d;
    logic [jas_pkg::IR_WIDTH-1:0] ir_q;
    logic [jas_pkg::IR_WIDTH-1:0] ir_d;
    logic [jas_pkg::IR_WIDTH-1:0] ir_sh_q;
    logic [jas_pkg::IR_WIDTH-1:0] ir_sh_d;
    logic [jas_pkg::ID_WIDTH-1:0] dr_q;
    logic [jas_pkg::ID_WIDTH-1:0] dr_d;

    // Next-state table, stepped on each rising test clock
    // Kept as a function so the table reads like the usual state diagram
    function automatic jas_pkg::jas_tap_state_t tap_next(input jas_pkg::jas_tap_state_t s, input logic tms);
        unique case (s)
            jas_pkg::TAP_RESET:    tap_next = tms ? jas_pkg::TAP_RESET   : jas_pkg::TAP_IDLE;
            jas_pkg::TAP_IDLE:     tap_next = tms ? jas_pkg::TAP_SEL_DR  : jas_pkg::TAP_IDLE;
            jas_pkg::TAP_SEL_DR:   tap_next = tms ? jas_pkg::TAP_SEL_IR  : jas_pkg::TAP_CAP_DR;
            jas_pkg::TAP_CAP_DR:   tap_next = tms ? jas_pkg::TAP_EXIT1_DR : jas_pkg::TAP_SHIFT_DR;
            jas_pkg::TAP_SHIFT_DR: tap_next = tms ? jas_pkg::TAP_EXIT1_DR : jas_pkg::TAP_SHIFT_DR;
            jas_pkg::TAP_EXIT1_DR: tap_next = tms ? jas_pkg::TAP_UPD_DR  : jas_pkg::TAP_PAUSE_DR;
            jas_pkg::TAP_PAUSE_DR: tap_next = tms ? jas_pkg::TAP_EXIT2_DR : jas_pkg::TAP_PAUSE_DR;
            jas_pkg::TAP_EXIT2_DR: tap_next = tms ? jas_pkg::TAP_UPD_DR  : jas_pkg::TAP_SHIFT_DR;
            jas_pkg::TAP_UPD_DR:   tap_next = tms ? jas_pkg::TAP_SEL_DR  : jas_pkg::TAP_IDLE;
            jas_pkg::TAP_SEL_IR:   tap_next = tms ? jas_pkg::TAP_RESET   : jas_pkg::TAP_CAP_IR;
            jas_pkg::TAP_CAP_IR:   tap_next = tms ? jas_pkg::TAP_EXIT1_IR : jas_pkg::TAP_SHIFT_IR;
            jas_pkg::TAP_SHIFT_IR: tap_next = tms ? jas_pkg::TAP_EXIT1_IR : jas_pkg::TAP_SHIFT_IR;
            jas_pkg::TAP_EXIT1_IR: tap_next = tms ? jas_pkg::TAP_UPD_IR  : jas_pkg::TAP_PAUSE_IR;
            jas_pkg::TAP_PAUSE_IR: tap_next = tms ? jas_pkg::TAP_EXIT2_IR : jas_pkg::TAP_PAUSE_IR;
            jas_pkg::TAP_EXIT2_IR: tap_next = tms ? jas_pkg::TAP_UPD_IR  : jas_pkg::TAP_SHIFT_IR;
            jas_pkg::TAP_UPD_IR:   tap_next = tms ? jas_pkg::TAP_SEL_DR  : jas_pkg::TAP_IDLE;
        endcase
    endfunction : tap_next

    // Controller stepping: capture, shift and update on rising test clock
    always_comb begin
        state_d = state_q;
        ir_d    = ir_q;
        ir_sh_d = ir_sh_q;
        dr_d    = dr_q;
        if (tck_rise) begin
            state_d = tap_next(state_q, mux_tms);
            unique case (state_q)
                jas_pkg::TAP_RESET: begin
                    ir_d = jas_pkg::IR_RESET_VAL;
                end
                jas_pkg::TAP_CAP_IR: begin
                    ir_sh_d = {{(jas_pkg::IR_WIDTH-2){1'b0}}, jas_pkg::IR_CAPTURE};
                end
                jas_pkg::TAP_SHIFT_IR: begin
                    ir_sh_d = {mux_tdi, ir_sh_q[jas_pkg::IR_WIDTH-1:1]};
                end
                jas_pkg::TAP_UPD_IR: begin
                    ir_d = ir_sh_q;
                end
                jas_pkg::TAP_CAP_DR: begin
                    dr_d = (ir_q == jas_pkg::IR_IDCODE) ? jas_pkg::ID_WORD : '0;
                end
                jas_pkg::TAP_SHIFT_DR: begin
                    // Bypass is one bit long; identification shifts the full word
                    if (ir_q == jas_pkg::IR_IDCODE) begin
                        dr_d = {mux_tdi, dr_q[jas_pkg::ID_WIDTH-1:1]};
                    end else begin
                        dr_d = {{(jas_pkg::ID_WIDTH-1){1'b0}}, mux_tdi};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Reset leaves the controller in its reset state with the identify code loaded
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_q <= jas_pkg::TAP_RESET;
            ir_q    <= jas_pkg::IR_RESET_VAL;
            ir_sh_q <= '0;
            dr_q    <= '0;
        end else begin
            state_q <= state_d;
            ir_q    <= ir_d;
            ir_sh_q <= ir_sh_d;
            dr_q    <= dr_d;
        end
    end

    // Serial output: updated on the falling test clock, routed to the live path only
    logic tdo_q;
    logic tdo_d;
    logic tdo_en_q;
    logic tdo_en_d;
    logic pin_tdo_q;
    logic pin_tdo_d;
    logic pin_oe_n_q;
    logic pin_oe_n_d;
    logic core_tdo_q;
    logic core_tdo_d;

    always_comb begin
        tdo_d    = tdo_q;
        tdo_en_d = tdo_en_q;
        // The bit is refreshed on every falling clock; the enable and the select decide if the pin drives it
        if (tck_fall) begin
            tdo_en_d = (state_q == jas_pkg::TAP_SHIFT_DR) || (state_q == jas_pkg::TAP_SHIFT_IR);
            tdo_d    = (state_q == jas_pkg::TAP_SHIFT_IR) ? ir_sh_q[0] : dr_q[0];
        end
        // Pin driver released while the core owns the controller
        // Gating follows the next select value so the outputs swap on the edge at which
        // the select register swaps; the old path never shows its last bit for a cycle
        pin_oe_n_d = ~(tdo_en_q & ~sel_d);
        pin_tdo_d  = sel_d ? 1'b0 : tdo_q;
        core_tdo_d = sel_d ? tdo_q : 1'b0;
    end

    // Reset parks the pin driver released and both serial outputs low
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            tdo_q      <= 1'b0;
            tdo_en_q   <= 1'b0;
            pin_tdo_q  <= 1'b0;
            pin_oe_n_q <= 1'b1;
            core_tdo_q <= 1'b0;
        end else begin
            tdo_q      <= tdo_d;
            tdo_en_q   <= tdo_en_d;
            pin_tdo_q  <= pin_tdo_d;
            pin_oe_n_q <= pin_oe_n_d;
            core_tdo_q <= core_tdo_d;
        end
    end

    // Outputs come straight from the registers above
    assign pin_tdo_o      = pin_tdo_q;
    assign pin_tdo_oe_n_o = pin_oe_n_q;
    assign core_tdo_o     = core_tdo_q;
    assign core_active_o  = sel_q;
endmodule : jas_access_select

// ===== testbench/jas_access_select_chk.sv
// Checker: port-level assertions for the access path selector
`timescale 1ns/100ps
module jas_chk (
    input wire logic clk_i, reset_n_i, pin_tck_i, pin_tdo_o, pin_tdo_oe_n_o,
    input wire logic core_sel_i, core_tck_i, core_tdo_o, core_active_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Reset parks the pin driver and hands control to the pins
    AST_RST_IDLE: assert property (@(posedge clk_i) disable iff (1'b0)
        !reset_n_i |=> pin_tdo_oe_n_o && !core_active_o) else $error("reset state wrong");
    // Select reaches the controller after the sync stages
    AST_SEL_LAT: assert property ($rose(core_sel_i) |-> ##[2:4] core_active_o)
        else $error("core path late");
    AST_DESEL_LAT: assert property ($fell(core_sel_i) |-> ##[2:4] !core_active_o)
        else $error("pin path late");
    AST_SEL_HOLD: assert property (core_sel_i [*5] |-> core_active_o)
        else $error("core path dropped");
    // Only one path ever drives serial out
    AST_PIN_OFF: assert property (core_active_o |-> pin_tdo_oe_n_o && !pin_tdo_o)
        else $error("pin driven while core owns");
    AST_CORE_OFF: assert property (!core_active_o |-> !core_tdo_o)
        else $error("core out while pins own");
    // Serial out moves only after a falling test clock or a path switch
    AST_PIN_STAND: assert property (pin_tck_i [*5] |-> $stable(pin_tdo_o))
        else $error("pin out moved in high phase");
    AST_CORE_STAND: assert property (core_tck_i [*5] |-> $stable(core_tdo_o))
        else $error("core out moved in high phase");
endmodule : jas_chk
bind jas_access_select jas_chk u_chk (.clk_i, .reset_n_i, .pin_tck_i, .pin_tdo_o, .pin_tdo_oe_n_o,
    .core_sel_i, .core_tck_i, .core_tdo_o, .core_active_o);

// ===== testbench/jas_tap_host.sv
// Partner model: test-access host clocking scans on one path
`timescale 1ns/100ps
module jas_tap_host (
    // Scan lines toward the selector
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    // Serial data back, an input unlike the other three
    input  wire logic tdo_i
);
    // Test clock stands still low between frames
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b0;
        tdi_o = 1'b0;
    end
    // One 125 ns test-clock period; out bit taken just before rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #62.5;
        tdo = tdo_i;
        tck_o = 1'b1;
        #62.5;
        tck_o = 1'b0;
    endtask : step
endmodule : jas_tap_host

// ===== testbench/tb_jas_access_select.sv
// Testbench: path selection and identify scans on both paths
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", n, e, a); end end
module tb_jas_access_select;
    logic        clk_i = 1'b0, reset_n_i = 1'b0, core_sel_i = 1'b0;
    logic        pin_tck_i, pin_tdi_i, pin_tms_i, core_tck_i, core_tdi_i, core_tms_i;
    logic        pin_tdo_o, pin_tdo_oe_n_o, core_tdo_o, core_active_o, t;
    logic [31:0] w;
    logic        pin_tdo_seen;
    // Released pin reads as the inverse of its last level
    assign pin_tdo_seen = pin_tdo_oe_n_o ? ~pin_tdo_o : pin_tdo_o;
    int          checked = 0, fail_count = 0, cyc = 0;
    jas_tap_host PH (.tck_o(pin_tck_i), .tms_o(pin_tms_i), .tdi_o(pin_tdi_i), .tdo_i(pin_tdo_seen));
    jas_tap_host CH (.tck_o(core_tck_i), .tms_o(core_tms_i), .tdi_o(core_tdi_i), .tdo_i(core_tdo_o));
    jas_access_select DUT (.clk_i, .reset_n_i, .pin_tck_i, .pin_tdi_i, .pin_tms_i, .pin_tdo_o,
        .pin_tdo_oe_n_o, .core_sel_i, .core_tck_i, .core_tdi_i, .core_tms_i, .core_tdo_o, .core_active_o);
    initial forever #5 clk_i = ~clk_i;
    // Hang guard: scans need about 1900 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    // Optional reset, idle, to shift the identify word, then back to idle
    task automatic scan(input bit c, input int s, output logic [31:0] r);
        logic m;
        @(posedge clk_i);
        #1;
        for (int i = s; i < 43; i++) begin
            m = (i < 5) || i == 6 || i == 40 || i == 41;
            if (c) CH.step(m, 1'b0, t);
            else PH.step(m, 1'b0, t);
            if (i > 8 && i < 41) r[i-9] = t;
            if (i == 20) `CHK("oe_n shift", c, pin_tdo_oe_n_o)
        end
    endtask : scan
    task automatic t_reset();
        `CHK("oe_n", 1'b1, pin_tdo_oe_n_o)
        `CHK("active", 1'b0, core_active_o)
        $display("t_reset done");
    endtask : t_reset
    // Core moves first but is ignored; pins walk on from reset state
    task automatic t_pin();
        foreach (w[i]) if (i < 4) CH.step(i == 1, 1'b0, t);
        scan(0, 5, w);
        `CHK("pin id", jas_pkg::ID_WORD, w)
        $display("t_pin done");
    endtask : t_pin
    task automatic t_core();
        @(posedge clk_i) core_sel_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        #1;
        `CHK("active", 1'b1, core_active_o)
        `CHK("oe_n", 1'b1, pin_tdo_oe_n_o)
        scan(1, 0, w);
        `CHK("core id", jas_pkg::ID_WORD, w)
        $display("t_core done");
    endtask : t_core
    task automatic t_back();
        @(posedge clk_i) core_sel_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        #1;
        `CHK("active", 1'b0, core_active_o)
        scan(0, 0, w);
        `CHK("pin id", jas_pkg::ID_WORD, w)
        $display("t_back done");
    endtask : t_back
    // Bypass code over the pins: capture pattern out, then a one-bit delay in the data path
    task automatic t_bypass();
        logic [18:0]                  tm;
        logic [18:0]                  ti;
        logic [7:0]                   o;
        logic [jas_pkg::IR_WIDTH-1:0] cap;
        logic                         b;
        tm  = 19'h3_0583;  // Select-IR, shift 4, update, select-DR, shift 4, update
        ti  = 19'h1_a0f0;  // Bypass code 4'hf, then 1, 0, 1, 1 through the data path
        o   = 8'h00;
        cap = {{(jas_pkg::IR_WIDTH-2){1'b0}}, jas_pkg::IR_CAPTURE};
        @(posedge clk_i);
        #1;
        for (int k = 0; k < 19; k++) begin
            PH.step(tm[k], ti[k], b);
            if (k > 3 && k < 8) o[k-4] = b;
            if (k > 12 && k < 17) o[k-9] = b;
        end
        `CHK("ir capture", cap, o[3:0])
        `CHK("bypass", 4'ha, o[7:4])
        $display("t_bypass done");
    endtask : t_bypass
    initial begin
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        t_reset();
        t_pin();
        t_core();
        t_back();
        t_bypass();
        tally_and_finish();
    end
endmodule : tb_jas_access_select
